// >>> saf_filter.sv
// Receive destination address filter and output bus map
`timescale 1ns/1ns
// Function
// - Filtering only with cascade select low
// - Multicast: any shared domain bit matches
// - Unicast: whole character must equal register
// - Match passes address and data; policy 3 drops address
// - Mismatching address blocks writes until next match
// - Power-up value all ones accepts everything but addresses dropped by policy 3
// - Device reset restores all-ones multicast value
// - Filter only with buffer enabled, policy nonzero
// - Reserved line is direction, special line mode
// - Register LSB on bus bit 0
// - Four output maps from bypass and width
// - Undecoded bit 0 is first serial bit
// - Policy 3 also removes serial addresses
module saf_filter #(
    parameter int ADDR_W = saf_pkg::ADDR_W,
    parameter int BUS_W  = saf_pkg::BUS_W
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             cascadeTimingSelect,
    input  wire logic             bufferBypassN,
    input  wire logic             coderBypassN,
    input  wire logic             charWidthSelect,
    input  wire logic [1:0]       discardPolicySel,
    input  wire logic             portSelectN,
    input  wire logic             rxPathResetN,
    input  wire logic             rxReadEnableN,
    input  wire logic [ADDR_W-1:0] rxBusIn,
    input  wire logic             rxReservedFlagIn,
    input  wire logic             rxSpecialNotDataIn,
    input  wire logic             charValid,
    input  wire logic             charIsAddress,
    input  wire logic [BUS_W-1:0] charData,
    input  wire logic             charSpecial,
    input  wire logic             charReserved,
    input  wire logic             charCellStart,
    input  wire logic             rxRemoteFlag,
    output logic                  fifoWrite,
    output logic [BUS_W-1:0]      fifoData,
    output logic                  fifoSpecial,
    output logic [BUS_W-1:0]      rxBusOut,
    output logic                  rxBusOe,
    output logic                  rxSpecialNotDataOut,
    output logic [ADDR_W-1:0]     addrValue,
    output logic                  addrUnicast,
    output logic                  accepting
);
    // ****************************************************************
    // State
    // ****************************************************************
    logic [ADDR_W-1:0] addr_q, addr_d;
    saf_pkg::saf_mode_t mode_q, mode_d;
    logic              accept_q, accept_d;
    logic              sel_q, sel_d;
    logic              fifoWrite_q, fifoWrite_d;
    logic [BUS_W-1:0]  fifoData_q, fifoData_d;
    logic              fifoSpecial_q, fifoSpecial_d;
    logic [BUS_W-1:0]  busOut_q, busOut_d;
    logic              busOe_q, busOe_d;
    logic              scdOut_q, scdOut_d;

    logic wide;
    logic match;
    logic promiscuous;
    logic filterOn;
    logic regAccess;
    logic regWrite;
    logic regRead;
    logic [ADDR_W-1:0] charAddr;

    // Byte width select low means ten-bit characters
    assign wide     = !charWidthSelect;
    assign charAddr = charData[ADDR_W-1:0];

    saf_matcher #(
        .ADDR_W (ADDR_W)
    ) u_matcher (
        .regValue    (addr_q),
        .rxAddr      (charAddr),
        .unicast     (mode_q == saf_pkg::SAF_UNICAST),
        .wide        (wide),
        .match       (match),
        .promiscuous (promiscuous)
    );

    // Filtering needs host timing, buffer enabled and a discarding policy
    assign filterOn = !cascadeTimingSelect
                   && bufferBypassN
                   && (discardPolicySel != saf_pkg::POLICY_KEEP);

    // Register reached only with port selected and path in reset
    assign regAccess = !portSelectN && !rxPathResetN && !rxReadEnableN;
    assign regWrite  = regAccess && !rxReservedFlagIn;
    assign regRead   = regAccess && rxReservedFlagIn;

    // ****************************************************************
    // Address register and acceptance
    // ****************************************************************
    always_comb begin
        addr_d   = addr_q;
        mode_d   = mode_q;
        accept_d = accept_q;
        if (regWrite) begin
            addr_d = rxBusIn;
            mode_d = rxSpecialNotDataIn ? saf_pkg::SAF_UNICAST
                                        : saf_pkg::SAF_MULTICAST;
            accept_d = 1'b0;
        end else if (charValid && charIsAddress) begin
            accept_d = match;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addr_q   <= saf_pkg::ADDR_RESET;
            mode_q   <= saf_pkg::SAF_MULTICAST;
            accept_q <= 1'b1;
        end else begin
            addr_q   <= addr_d;
            mode_q   <= mode_d;
            accept_q <= accept_d;
        end
    end

    // ****************************************************************
    // Receive buffer write path
    // ****************************************************************
    // Promiscuous value overrides acceptance so that all traffic passes except addresses dropped by policy 3
    always_comb begin
        logic pass;
        logic isAddr;
        pass   = 1'b1;
        isAddr = charValid && charIsAddress;
        fifoData_d    = charData;
        fifoSpecial_d = charSpecial;
        if (filterOn && !promiscuous) begin
            pass = isAddr ? match : accept_q;
        end
        if (isAddr && filterOn && (discardPolicySel == saf_pkg::POLICY_DROPA)) begin
            pass = 1'b0;
        end
        fifoWrite_d = charValid && pass && rxPathResetN;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fifoWrite_q   <= 1'b0;
            fifoData_q    <= '0;
            fifoSpecial_q <= 1'b0;
        end else begin
            fifoWrite_q   <= fifoWrite_d;
            fifoData_q    <= fifoData_d;
            fifoSpecial_q <= fifoSpecial_d;
        end
    end

    // ****************************************************************
    // Output register and bus map
    // ****************************************************************
    always_comb begin
        sel_d    = !portSelectN;
        // A register read drives the bus too, or the host would sample a floating answer
        busOe_d  = (sel_q && !rxReadEnableN) || regRead;
        busOut_d = busOut_q;
        scdOut_d = scdOut_q;
        if (regRead) begin
            busOut_d = '0;
            busOut_d[ADDR_W-1:0] = wide ? addr_q : (addr_q & saf_pkg::ADDR_ALL8);
            scdOut_d = (mode_q == saf_pkg::SAF_UNICAST);
        end else if (sel_q && !rxReadEnableN) begin
            // Undecoded data keeps the first serial bit in bit 0 as received
            busOut_d = fifoData_q;
            scdOut_d = coderBypassN ? fifoSpecial_q : 1'b0;
            if (coderBypassN) begin
                busOut_d[saf_pkg::RSV_BIT] = charReserved;
                busOut_d[saf_pkg::SOC_BIT] = charCellStart;
                if (!wide) begin
                    busOut_d[9] = 1'b0;
                    busOut_d[saf_pkg::RX_FLAG_BIT] = bufferBypassN ? rxRemoteFlag
                                                                   : 1'b0;
                end
            end else if (!wide) begin
                busOut_d[saf_pkg::RSV_BIT] = 1'b0;
                busOut_d[saf_pkg::SOC_BIT] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sel_q    <= 1'b0;
            busOe_q  <= 1'b0;
            busOut_q <= '0;
            scdOut_q <= 1'b0;
        end else begin
            sel_q    <= sel_d;
            busOe_q  <= busOe_d;
            busOut_q <= busOut_d;
            scdOut_q <= scdOut_d;
        end
    end

    assign fifoWrite           = fifoWrite_q;
    assign fifoData            = fifoData_q;
    assign fifoSpecial         = fifoSpecial_q;
    assign rxBusOut            = busOut_q;
    assign rxBusOe             = busOe_q;
    assign rxSpecialNotDataOut = scdOut_q;
    assign addrValue           = addr_q;
    assign addrUnicast         = (mode_q == saf_pkg::SAF_UNICAST);
    assign accepting           = accept_q;
endmodule

// >>> saf_pkg.sv
// Constants and types shared by the serial address filter
package saf_pkg;
    // ****************************************************************
    // Widths and reset values
    // ****************************************************************
    localparam int          ADDR_W       = 10;
    localparam int          BUS_W        = 12;
    localparam logic [9:0]  ADDR_RESET   = 10'h3FF;
    localparam logic [9:0]  ADDR_ALL8    = 10'h0FF;
    localparam logic [1:0]  POLICY_KEEP  = 2'h0;
    localparam logic [1:0]  POLICY_DROPA = 2'h3;
    localparam int          RX_FLAG_BIT  = 8;
    localparam int          RSV_BIT      = 10;
    localparam int          SOC_BIT      = 11;

    typedef enum logic { SAF_MULTICAST, SAF_UNICAST } saf_mode_t;
endpackage

// >>> saf_matcher.sv
// Address comparison for multicast and unicast modes
`timescale 1ns/1ns
module saf_matcher #(
    parameter int ADDR_W = saf_pkg::ADDR_W
) (
    input  wire logic [ADDR_W-1:0] regValue,
    input  wire logic [ADDR_W-1:0] rxAddr,
    input  wire logic              unicast,
    input  wire logic              wide,
    output logic                   match,
    output logic                   promiscuous
);
    logic [ADDR_W-1:0] mask;
    logic [ADDR_W-1:0] hits;

    // Narrow characters only use the low eight bits
    genvar i;
    generate
        for (i = 0; i < ADDR_W; i++) begin : g_bit
            assign mask[i] = (i < 8) ? 1'b1 : wide;
            assign hits[i] = regValue[i] & rxAddr[i] & mask[i];
        end
    endgenerate

    always_comb begin
        if (unicast) begin
            match = ((regValue ^ rxAddr) & mask) == '0;
        end else begin
            match = |hits;
        end
        promiscuous = !unicast && ((regValue & mask) == mask);
    end
endmodule

// >>> saf_filter_monitor.sv
// Checker of the serial address filter port behaviour
`timescale 1ns/1ns
module saf_filter_monitor (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        portSelectN,
    input wire logic        rxPathResetN,
    input wire logic        rxReadEnableN,
    input wire logic        rxReservedFlagIn,
    input wire logic        rxSpecialNotDataIn,
    input wire logic [9:0]  rxBusIn,
    input wire logic        charValid,
    input wire logic        fifoWrite,
    input wire logic [11:0] rxBusOut,
    input wire logic        rxBusOe,
    input wire logic        rxSpecialNotDataOut,
    input wire logic [9:0]  addrValue,
    input wire logic        addrUnicast,
    input wire logic        accepting
);
    // ****
    // Register access and receive path checks
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire acc = !portSelectN && !rxPathResetN && !rxReadEnableN;
    wire wr  = acc && !rxReservedFlagIn;
    wire rd  = acc && rxReservedFlagIn;
    sequence selThenRead;
        !portSelectN ##1 (!rxReadEnableN && rxPathResetN);
    endsequence
    rst_values_a: assert property ($rose(rstn) |-> addrValue == 10'h3FF
        && accepting && !addrUnicast) else $error("reset value wrong");
    write_update_a: assert property (wr |=> addrValue == $past(rxBusIn)
        && addrUnicast == $past(rxSpecialNotDataIn)) else $error("write not stored");
    value_hold_a: assert property (!wr |=> $stable(addrValue)
        && $stable(addrUnicast)) else $error("register changed without write");
    write_blocks_a: assert property (wr && (rxSpecialNotDataIn || rxBusIn[7:0] != 8'hFF)
        |=> !accepting) else $error("not blocked after write");
    path_block_a: assert property (!rxPathResetN |=> !fifoWrite)
        else $error("buffer write during path reset");
    idle_char_a: assert property (!charValid |=> !fifoWrite)
        else $error("buffer write without character");
    read_drive_a: assert property (selThenRead |=> rxBusOe)
        else $error("bus not driven on read");
    read_answer_a: assert property (rd |=> rxBusOut[7:0] == $past(addrValue[7:0])
        && rxSpecialNotDataOut == $past(addrUnicast) && rxBusOe) else $error("read answer wrong");
endmodule
bind saf_filter saf_filter_monitor mon (.clk, .rstn, .portSelectN, .rxPathResetN,
    .rxReadEnableN, .rxReservedFlagIn, .rxSpecialNotDataIn, .rxBusIn, .charValid, .fifoWrite,
    .rxBusOut, .rxBusOe, .rxSpecialNotDataOut, .addrValue, .addrUnicast, .accepting);

// >>> saf_host_model.sv
// Host controller model for the receive port
`timescale 1ns/1ns
module saf_host_model (
    input  wire logic  clk,
    output logic       portSelectN,
    output logic       rxPathResetN,
    output logic       rxReadEnableN,
    output logic [9:0] rxBusIn,
    output logic       rxReservedFlagIn,
    output logic       rxSpecialNotDataIn
);
    // ****
    // Access sequences, driven after the falling edge
    // ****
    initial begin
        {portSelectN, rxPathResetN, rxReadEnableN} = 3'h7;
        {rxReservedFlagIn, rxSpecialNotDataIn} = 2'h0;
        rxBusIn = 10'h155;
    end
    // Released bus is inverted so a stale value never looks like an answer
    task automatic regAccess(input logic rd, input logic mode, input logic [9:0] v);
        @(negedge clk);
        {portSelectN, rxPathResetN, rxReadEnableN} = 3'h0;
        {rxReservedFlagIn, rxSpecialNotDataIn} = {rd, mode};
        rxBusIn = rd ? ~rxBusIn : v;
        @(negedge clk);
        {portSelectN, rxPathResetN, rxReadEnableN} = 3'h7;
        rxBusIn = ~rxBusIn;
    endtask
    task automatic fifoRead();
        @(negedge clk);
        portSelectN = 1'b0;
        @(negedge clk);
        portSelectN = 1'b1;
        rxReadEnableN = 1'b0;
        @(negedge clk);
        rxReadEnableN = 1'b1;
    endtask
endmodule

// >>> tb_saf_filter.sv
// Self-checking testbench of the serial address filter
`timescale 1ns/1ns
module tb_saf_filter;
    logic        clk = 1'b0, rstn = 1'b0, cascadeTimingSelect = 1'b0, bufferBypassN = 1'b1;
    logic        coderBypassN = 1'b1, charWidthSelect = 1'b0, charValid = 1'b0;
    logic        charIsAddress = 1'b0, charSpecial = 1'b0, charReserved = 1'b0;
    logic        charCellStart = 1'b0, rxRemoteFlag = 1'b0;
    logic [1:0]  discardPolicySel = 2'h1;
    logic [11:0] charData = 12'h000;
    wire         portSelectN, rxPathResetN, rxReadEnableN, rxReservedFlagIn, rxSpecialNotDataIn;
    wire         fifoWrite, fifoSpecial, rxBusOe, rxSpecialNotDataOut, addrUnicast, accepting;
    wire [9:0]   rxBusIn, addrValue;
    wire [11:0]  fifoData, rxBusOut;
    int          nMismatch = 0, nChecks = 0;
    always #5 clk = ~clk;
    saf_host_model host (.clk, .portSelectN, .rxPathResetN, .rxReadEnableN, .rxBusIn,
        .rxReservedFlagIn, .rxSpecialNotDataIn);
    saf_filter dut (.clk, .rstn, .cascadeTimingSelect, .bufferBypassN, .coderBypassN,
        .charWidthSelect, .discardPolicySel, .portSelectN, .rxPathResetN, .rxReadEnableN,
        .rxBusIn, .rxReservedFlagIn, .rxSpecialNotDataIn, .charValid, .charIsAddress,
        .charData, .charSpecial, .charReserved, .charCellStart, .rxRemoteFlag, .fifoWrite,
        .fifoData, .fifoSpecial, .rxBusOut, .rxBusOe, .rxSpecialNotDataOut, .addrValue,
        .addrUnicast, .accepting);
    // ****
    // Shared tasks
    // ****
    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        nChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic sendChar(input logic addr, input logic [11:0] d, input logic exp);
        @(negedge clk);
        {charValid, charIsAddress, charData} = {1'b1, addr, d};
        @(negedge clk);
        charValid = 1'b0;
        cmp({11'h0, fifoWrite}, {11'h0, exp});
        if (exp) cmp(fifoData, d);
    endtask
    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", nChecks, nMismatch);
        if (nMismatch == 0 && nChecks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        cmp({2'h0, addrValue}, {2'h0, saf_pkg::ADDR_RESET});
        sendChar(1'b1, 12'h000, 1'b1);
        sendChar(1'b0, 12'h0AB, 1'b1);
        $display("test promiscuous done");
        host.regAccess(1'b0, 1'b0, 10'h005);
        cmp({2'h0, addrValue}, 12'h005);
        sendChar(1'b0, 12'h011, 1'b0);
        sendChar(1'b1, 12'h004, 1'b1);
        sendChar(1'b0, 12'h022, 1'b1);
        sendChar(1'b1, 12'h018, 1'b0);
        sendChar(1'b0, 12'h033, 1'b0);
        $display("test multicast done");
        host.regAccess(1'b0, 1'b1, 10'h2A5);
        host.regAccess(1'b1, 1'b1, 10'h000);
        cmp({2'h0, rxBusOut[9:0]}, 12'h2A5);
        cmp({11'h0, rxSpecialNotDataOut}, 12'h001);
        cmp({11'h0, rxBusOe}, 12'h001);
        sendChar(1'b1, 12'h2A4, 1'b0);
        sendChar(1'b1, 12'h2A5, 1'b1);
        sendChar(1'b1, 12'h0A5, 1'b0);
        $display("test unicast done");
        discardPolicySel = saf_pkg::POLICY_DROPA;
        sendChar(1'b1, 12'h2A5, 1'b0);
        sendChar(1'b0, 12'h044, 1'b1);
        {discardPolicySel, cascadeTimingSelect} = 3'h3;
        sendChar(1'b1, 12'h001, 1'b1);
        {discardPolicySel, cascadeTimingSelect} = {saf_pkg::POLICY_KEEP, 1'b0};
        sendChar(1'b1, 12'h002, 1'b1);
        {discardPolicySel, bufferBypassN} = 3'h2;
        sendChar(1'b1, 12'h003, 1'b1);
        {discardPolicySel, bufferBypassN, charReserved} = 4'h3;
        $display("test filter enables done");
        sendChar(1'b0, 12'h3C3, 1'b1);
        host.fifoRead();
        cmp(rxBusOut, 12'h7C3);
        cmp({11'h0, rxBusOe}, 12'h001);
        coderBypassN = 1'b0;
        sendChar(1'b0, 12'hA5C, 1'b1);
        host.fifoRead();
        cmp(rxBusOut, 12'hA5C);
        {coderBypassN, charWidthSelect, rxRemoteFlag, charReserved, charCellStart} = 5'h1D;
        sendChar(1'b0, 12'h3C3, 1'b1);
        host.fifoRead();
        cmp(rxBusOut, 12'h9C3);
        $display("test output maps done");
        rstn = 1'b0;
        @(negedge clk);
        rstn = 1'b1;
        cmp({1'b0, addrUnicast, addrValue}, 12'h3FF);
        $display("test device reset done");
        tallyAndFinish();
    end
endmodule
